// ---- hw/scpg_params.svh ----
`ifndef SCPG_PARAMS_SVH
`define SCPG_PARAMS_SVH

// Register byte offsets
`define SCPG_OFS_CTRL      8'h00
`define SCPG_OFS_PEAK      8'h04
`define SCPG_OFS_USTEP     8'h08
`define SCPG_OFS_DAMP      8'h0C
`define SCPG_OFS_IDLE      8'h10
`define SCPG_OFS_AREA0     8'h14
`define SCPG_OFS_AREA5     8'h28
`define SCPG_OFS_TGCFG     8'h2C
`define SCPG_OFS_TGREP     8'h30
`define SCPG_OFS_TGDIST    8'h34
`define SCPG_OFS_TGVEL     8'h38
`define SCPG_OFS_TGCMD     8'h3C
`define SCPG_OFS_STAT      8'h40

// Control register bit positions
`define SCPG_CTRL_FMT      0
`define SCPG_CTRL_DIRPOL   1
`define SCPG_CTRL_ALMHI    2
`define SCPG_CTRL_ENLOW    3
`define SCPG_CTRL_PHEN     4
`define SCPG_CTRL_STEN     5
`define SCPG_CTRL_SMOOTH   6
`define SCPG_CTRL_ENARST   7

// Reset values and limits
`define SCPG_RST_CTRL      8'h14
`define SCPG_RST_PEAK      7'h1E
`define SCPG_PEAK_MIN      7'h01
`define SCPG_PEAK_MAX      7'h52
`define SCPG_RST_USTEP     10'h010
`define SCPG_USTEP_MIN     10'h001
`define SCPG_USTEP_MAX     10'h200
`define SCPG_RST_DAMP      16'h0BB8
`define SCPG_RST_IDLE_PCT  7'h32
`define SCPG_PCT_FULL      7'h64
`define SCPG_RST_IDLE_MS   16'h01F4
`define SCPG_RST_AREA      96'h0080_0080_0000_0000_0000_0000
`define SCPG_RST_TG_INTV   16'h0064
`define SCPG_RST_TG_REP    16'h0001
`define SCPG_RST_TG_DIST   16'h0001
`define SCPG_RST_TG_VEL    24'h009C40
`define SCPG_FULL_STEPS    8'hC8

// Timing
`define SCPG_CLK_NS        25
`define SCPG_MS_NS         1000000
`define SCPG_MS_CYCLES     (`SCPG_MS_NS / `SCPG_CLK_NS)
`define SCPG_FILT_CYCLES   4

`endif

// ---- hw/scpg_pkg.sv ----
package scpg_pkg;

    typedef enum logic [1:0] {TG_IDLE, TG_MOVE, TG_PAUSE} scpg_tg_state_e;

    typedef struct packed {
        logic [7:0]        ctrl;
        logic [6:0]        peak;
        logic [9:0]        ustep;
        logic [15:0]       damp;
        logic [6:0]        idle_pct;
        logic [15:0]       idle_ms;
        logic [5:0][15:0]  area;
        logic              tg_bidir;
        logic              tg_pos;
        logic [15:0]       tg_intv;
        logic [15:0]       tg_reps;
        logic [15:0]       tg_dist;
        logic [23:0]       tg_vel_cfg;
        logic [31:0]       prdata;
        logic              pslverr;
        logic              alarm;
        logic              ph_lat;
        logic              st_lat;
        logic              ena_prev;
        logic              drv_rst;
        logic [15:0]       ms_cnt;
        logic [15:0]       idle_cnt;
        logic              reduced;
        logic              step;
        logic              dir;
        logic [9:0]        us_pos;
        logic              full_step;
        logic [6:0]        cur_ref;
        scpg_tg_state_e    tg_st;
        logic              tg_dir;
        logic              tg_leg;
        logic [23:0]       tg_vel;
        logic [23:0]       tg_tmr;
        logic [9:0]        tg_us;
        logic [7:0]        tg_fs;
        logic [15:0]       tg_rev;
        logic [15:0]       tg_rep;
        logic [15:0]       tg_pause;
    } scpg_main_s;

    typedef struct packed {
        logic              prev;
    } scpg_edge_s;

endpackage : scpg_pkg

// ---- hw/scpg_deglitch.sv ----
`timescale 1ns/1ps
`default_nettype none

module scpg_deglitch
    import scpg_pkg::*;
#(
    parameter int CNT_W   = 3,
    parameter int STABLE  = 4
)
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic en,
    input  wire logic sig,
    output logic      sig_out
);

    localparam logic [CNT_W-1:0] LAST = CNT_W'(STABLE - 1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             lvl;
    } scpg_dg_s;

    scpg_dg_s s_q;
    scpg_dg_s s_d;

    // Level moves only after the input held a new value long enough
    always_comb
    begin
        s_d = s_q;
        if (sig == s_q.lvl)
        begin
            s_d.cnt = '0;
        end
        else if (s_q.cnt == LAST)
        begin
            s_d.lvl = sig;
            s_d.cnt = '0;
        end
        else
        begin
            s_d.cnt = s_q.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Bypass adds no latency when smoothing is off
    assign sig_out = en ? s_q.lvl : sig;

endmodule : scpg_deglitch

`default_nettype wire

// ---- hw/scpg_edge_pick.sv ----
`timescale 1ns/1ps
`default_nettype none

module scpg_edge_pick
    import scpg_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic fall_sel,
    input  wire logic sig,
    output logic      edge_ev
);

    scpg_edge_s s_q;
    scpg_edge_s s_d;

    always_comb
    begin
        s_d      = s_q;
        s_d.prev = sig;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Edge chosen by switch only
    assign edge_ev = fall_sel ? (s_q.prev & ~sig) : (~s_q.prev & sig);

endmodule : scpg_edge_pick

`default_nettype wire

// ---- hw/scpg_core.sv ----
// Functional notes
// - Peak current 0.1 to 8.2 A
// - Microsteps per full step 1 to 512
// - Idle longer than limit reduces current
// - Damping coefficient resets to 3000
// - Alarm output polarity is configurable
// - Inputs are pulse/dir or cw/ccw
// - Direction level polarity, pulse/dir mode only
// - Active edge only from selector switch
// - Phase fault alarms only when enabled
// - Stall alarms only when enabled
// - Optional smoothing filter on command inputs
// - Enable toggle clears alarm when allowed
// - Enable input polarity is configurable
// - Anti-resonance active when any setting nonzero
// - Three areas, defaults zero and 128
// - Test motion one-way or back-and-forth
// - Test first direction is selectable
// - Test pause in milliseconds between repeats
// - Test runs configured repeat count
// - Test move distance in revolutions
// - Test velocity sampled at direction change
// - Start/stop command launches or halts test
`timescale 1ns/1ps
`default_nettype none
`include "scpg_params.svh"

module scpg_core
    import scpg_pkg::*;
#(
    parameter int MS_CYCLES  = `SCPG_MS_CYCLES,
    parameter int FILT_STABLE = `SCPG_FILT_CYCLES
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmd_in_a,
    input  wire logic        cmd_in_b,
    input  wire logic        edge_selector_switch,
    input  wire logic        drive_enable_input,
    input  wire logic        phase_fault_in,
    input  wire logic        stall_in,
    output logic             step_pulse,
    output logic             step_dir,
    output logic             full_step_pulse,
    output logic [6:0]       current_ref,
    output logic [6:0]       peak_current_setting,
    output logic [9:0]       microstep_res,
    output logic [15:0]      electronic_damping_coeff,
    output logic [95:0]      antires_settings,
    output logic             antires_active,
    output logic             alarm_out,
    output logic             drive_enabled,
    output logic             drive_reset_pulse,
    output logic             tg_running
);

    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
    scpg_main_s s_q;
    scpg_main_s s_d;
    logic filt_a;
    logic filt_b;
    logic ev_a;
    logic ev_b;
    logic pulse_edge_select;
    // Active edge comes from the switch, never from a register
    assign pulse_edge_select = edge_selector_switch;
    // Ripple filters, one per command line
    scpg_deglitch #(.CNT_W(8), .STABLE(FILT_STABLE)) u_filt_a (.pclk(pclk), .presetn(presetn),
        .en(s_q.ctrl[`SCPG_CTRL_SMOOTH]), .sig(cmd_in_a), .sig_out(filt_a));
    scpg_deglitch #(.CNT_W(8), .STABLE(FILT_STABLE)) u_filt_b (.pclk(pclk), .presetn(presetn),
        .en(s_q.ctrl[`SCPG_CTRL_SMOOTH]), .sig(cmd_in_b), .sig_out(filt_b));
    // Edge detectors behind the filters
    scpg_edge_pick u_edge_a (.pclk(pclk), .presetn(presetn), .fall_sel(pulse_edge_select),
        .sig(filt_a), .edge_ev(ev_a));
    scpg_edge_pick u_edge_b (.pclk(pclk), .presetn(presetn), .fall_sel(pulse_edge_select),
        .sig(filt_b), .edge_ev(ev_b));
    // Zero wait states: read data is prepared in the setup cycle
    assign pready = 1'b1;
    always_comb
    begin
        logic        wr, rd_set, mapped, tg_cmd, enabled, ena_lvl, ph_ev, st_ev;
        logic        ms_tick, ext_step, ext_dir, tg_step, do_step, nxt_dir, move_done;
        logic [31:0] rv;
        logic [31:0] wv;
        logic [2:0]  aidx;
        logic [13:0] prod;
        logic [13:0] quot;
        s_d       = s_q;
        wr        = psel & penable & pwrite;
        rd_set    = psel & ~penable;
        mapped    = 1'b1;
        rv        = 32'h0000_0000;
        wv        = 32'h0000_0000;
        aidx      = 3'(({24'h0, paddr} - {24'h0, `SCPG_OFS_AREA0}) >> 2);
        tg_cmd    = 1'b0;
        tg_step   = 1'b0;
        ext_step  = 1'b0;
        ext_dir   = s_q.dir;
        move_done = 1'b0;
        do_step   = 1'b0;
        nxt_dir   = 1'b0;
        ms_tick   = (s_q.ms_cnt == MS_LAST);
        ena_lvl   = drive_enable_input;
        enabled   = s_q.ctrl[`SCPG_CTRL_ENLOW] ? ~ena_lvl : ena_lvl;
        ph_ev     = phase_fault_in & s_q.ctrl[`SCPG_CTRL_PHEN];
        st_ev     = stall_in & s_q.ctrl[`SCPG_CTRL_STEN];
        prod      = 14'(s_q.peak) * 14'(s_q.idle_pct); // Widened first, so it cannot wrap
        quot      = prod / 14'h64;
        // Read mux and address decode
        unique case (paddr)
            `SCPG_OFS_CTRL:  rv = {24'h0, s_q.ctrl};
            `SCPG_OFS_PEAK:  rv = {25'h0, s_q.peak};
            `SCPG_OFS_USTEP: rv = {22'h0, s_q.ustep};
            `SCPG_OFS_DAMP:  rv = {16'h0, s_q.damp};
            `SCPG_OFS_IDLE:  rv = {s_q.idle_ms, 9'h0, s_q.idle_pct};
            `SCPG_OFS_TGCFG: rv = {s_q.tg_intv, 14'h0, s_q.tg_pos, s_q.tg_bidir};
            `SCPG_OFS_TGREP: rv = {16'h0, s_q.tg_reps};
            `SCPG_OFS_TGDIST: rv = {16'h0, s_q.tg_dist};
            `SCPG_OFS_TGVEL: rv = {8'h0, s_q.tg_vel_cfg};
            `SCPG_OFS_TGCMD: rv = 32'h0000_0000;
            `SCPG_OFS_STAT:  rv = {25'h0, s_q.st_lat, s_q.ph_lat, drive_enabled,
                                   antires_active, s_q.reduced,
                                   (s_q.tg_st != TG_IDLE), s_q.alarm};
            default:
                if (paddr >= `SCPG_OFS_AREA0 && paddr <= `SCPG_OFS_AREA5 && paddr[1:0] == 2'b00)
                    rv = {16'h0, s_q.area[aidx]};
                else
                    mapped = 1'b0;
        endcase
        if (rd_set)
        begin
            s_d.prdata  = pwrite ? 32'h0000_0000 : rv;
            s_d.pslverr = ~mapped;
        end
        // Register writes: byte lanes merge into the old value, then clamp
        if (wr && mapped)
        begin
            for (int i = 0; i < 4; i++)
                wv[i*8 +: 8] = pstrb[i] ? pwdata[i*8 +: 8] : rv[i*8 +: 8];
            unique case (paddr)
                `SCPG_OFS_CTRL:  s_d.ctrl = wv[7:0];
                `SCPG_OFS_PEAK:
                    if (wv[31:7] != 25'h0 || wv[6:0] > `SCPG_PEAK_MAX)
                        s_d.peak = `SCPG_PEAK_MAX;
                    else if (wv[6:0] < `SCPG_PEAK_MIN)
                        s_d.peak = `SCPG_PEAK_MIN;
                    else
                        s_d.peak = wv[6:0];
                `SCPG_OFS_USTEP:
                    if (wv[31:10] != 22'h0 || wv[9:0] > `SCPG_USTEP_MAX)
                        s_d.ustep = `SCPG_USTEP_MAX;
                    else if (wv[9:0] < `SCPG_USTEP_MIN)
                        s_d.ustep = `SCPG_USTEP_MIN;
                    else
                        s_d.ustep = wv[9:0];
                `SCPG_OFS_DAMP:  s_d.damp = wv[15:0];
                `SCPG_OFS_IDLE:
                begin
                    s_d.idle_ms  = wv[31:16];
                    s_d.idle_pct = (wv[6:0] > `SCPG_PCT_FULL) ? `SCPG_PCT_FULL : wv[6:0];
                end
                `SCPG_OFS_TGCFG:
                begin
                    s_d.tg_bidir = wv[0];
                    s_d.tg_pos   = wv[1];
                    s_d.tg_intv  = wv[31:16];
                end
                `SCPG_OFS_TGREP:  s_d.tg_reps = wv[15:0];
                `SCPG_OFS_TGDIST: s_d.tg_dist = wv[15:0];
                `SCPG_OFS_TGVEL:  s_d.tg_vel_cfg = (wv[23:0] == 24'h0) ? 24'h000001 : wv[23:0];
                `SCPG_OFS_TGCMD:  tg_cmd = wv[0];
                `SCPG_OFS_STAT:   tg_cmd = 1'b0;
                default:          s_d.area[aidx] = wv[15:0];
            endcase
        end
        // Millisecond time base
        s_d.ms_cnt = ms_tick ? 16'h0000 : s_q.ms_cnt + 16'h0001;
        // Fault latching; a fault beats an enable-toggle clear
        s_d.ena_prev = ena_lvl;
        s_d.drv_rst  = 1'b0;
        if (s_q.alarm && s_q.ctrl[`SCPG_CTRL_ENARST] && (ena_lvl != s_q.ena_prev))
        begin
            s_d.alarm   = 1'b0;
            s_d.ph_lat  = 1'b0;
            s_d.st_lat  = 1'b0;
            s_d.drv_rst = 1'b1;
        end
        s_d.alarm  = s_d.alarm | ph_ev | st_ev;
        s_d.ph_lat = s_d.ph_lat | ph_ev;
        s_d.st_lat = s_d.st_lat | st_ev;
        // External command decode
        if (!s_q.ctrl[`SCPG_CTRL_FMT])
        begin
            ext_step = ev_a;
            ext_dir  = s_q.ctrl[`SCPG_CTRL_DIRPOL] ? filt_b : ~filt_b;
        end
        else if (ev_a ^ ev_b)
        begin
            ext_step = 1'b1;
            ext_dir  = ev_a;
        end
        // Internal test generator
        unique case (s_q.tg_st)
            TG_IDLE:
                if (tg_cmd && s_q.tg_reps != 16'h0 && s_q.tg_dist != 16'h0)
                begin
                    s_d.tg_st  = TG_MOVE;
                    s_d.tg_dir = s_q.tg_pos;
                    s_d.tg_leg = 1'b0;
                    s_d.tg_vel = s_q.tg_vel_cfg;
                    s_d.tg_tmr = 24'h0;
                    s_d.tg_us  = 10'h0;
                    s_d.tg_fs  = 8'h0;
                    s_d.tg_rev = 16'h0;
                    s_d.tg_rep = 16'h0;
                end
            TG_MOVE:
                if (tg_cmd)
                    s_d.tg_st = TG_IDLE;
                else if (s_q.tg_tmr + 24'h1 >= s_q.tg_vel)
                begin
                    s_d.tg_tmr = 24'h0;
                    tg_step    = 1'b1;
                    s_d.tg_us  = s_q.tg_us + 10'h1;
                    if (s_q.tg_us + 10'h1 >= s_q.ustep)
                    begin
                        s_d.tg_us = 10'h0;
                        s_d.tg_fs = s_q.tg_fs + 8'h1;
                        if (s_q.tg_fs + 8'h1 == `SCPG_FULL_STEPS)
                        begin
                            s_d.tg_fs  = 8'h0;
                            s_d.tg_rev = s_q.tg_rev + 16'h1;
                            move_done  = (s_q.tg_rev + 16'h1 == s_q.tg_dist);
                        end
                    end
                    if (move_done)
                    begin
                        s_d.tg_rev = 16'h0;
                        if (s_q.tg_bidir && !s_q.tg_leg)
                        begin
                            s_d.tg_leg = 1'b1;
                            s_d.tg_dir = ~s_q.tg_dir;
                            s_d.tg_vel = s_q.tg_vel_cfg;
                        end
                        else
                        begin
                            s_d.tg_rep   = s_q.tg_rep + 16'h1;
                            s_d.tg_leg   = 1'b0;
                            s_d.tg_pause = 16'h0;
                            s_d.tg_st    = (s_q.tg_rep + 16'h1 == s_q.tg_reps) ?
                                           TG_IDLE : TG_PAUSE;
                        end
                    end
                end
                else
                    s_d.tg_tmr = s_q.tg_tmr + 24'h1;
            TG_PAUSE:
                if (tg_cmd)
                    s_d.tg_st = TG_IDLE;
                else if (s_q.tg_pause == s_q.tg_intv)
                begin
                    s_d.tg_st  = TG_MOVE;
                    s_d.tg_tmr = 24'h0;
                    if (s_q.tg_bidir)
                    begin
                        s_d.tg_dir = ~s_q.tg_dir;
                        s_d.tg_vel = s_q.tg_vel_cfg;
                    end
                end
                else if (ms_tick)
                    s_d.tg_pause = s_q.tg_pause + 16'h1;
        endcase
        // Motion path: test generator owns the motor while running
        do_step = ((s_q.tg_st != TG_IDLE) ? tg_step : ext_step) & enabled & ~s_q.alarm;
        nxt_dir = (s_q.tg_st != TG_IDLE) ? s_q.tg_dir : ext_dir;
        s_d.step      = do_step;
        s_d.full_step = 1'b0;
        if (do_step)
        begin
            s_d.dir = nxt_dir;
            if (nxt_dir)
            begin
                s_d.us_pos = s_q.us_pos + 10'h1;
                if (s_q.us_pos + 10'h1 >= s_q.ustep)
                begin
                    s_d.us_pos    = 10'h0;
                    s_d.full_step = 1'b1;
                end
            end
            else if (s_q.us_pos == 10'h0 || s_q.us_pos >= s_q.ustep)
            begin
                s_d.us_pos    = s_q.ustep - 10'h1;
                s_d.full_step = 1'b1;
            end
            else
                s_d.us_pos = s_q.us_pos - 10'h1;
        end
        // Idle timer restarts on each accepted step
        if (do_step)
            s_d.idle_cnt = 16'h0;
        else if (ms_tick && s_q.idle_cnt != 16'hFFFF)
            s_d.idle_cnt = s_q.idle_cnt + 16'h1;
        s_d.reduced = ~do_step & (s_q.reduced | (s_q.idle_cnt > s_q.idle_ms));
        // Winding reference: peak, or a share of it while idle
        s_d.cur_ref = s_q.reduced ? quot[6:0] : s_q.peak;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q            <= '0;
            s_q.ctrl       <= `SCPG_RST_CTRL;
            s_q.peak       <= `SCPG_RST_PEAK;
            s_q.ustep      <= `SCPG_RST_USTEP;
            s_q.damp       <= `SCPG_RST_DAMP;
            s_q.idle_pct   <= `SCPG_RST_IDLE_PCT;
            s_q.idle_ms    <= `SCPG_RST_IDLE_MS;
            s_q.area       <= `SCPG_RST_AREA;
            s_q.tg_intv    <= `SCPG_RST_TG_INTV;
            s_q.tg_reps    <= `SCPG_RST_TG_REP;
            s_q.tg_dist    <= `SCPG_RST_TG_DIST;
            s_q.tg_vel_cfg <= `SCPG_RST_TG_VEL;
            s_q.cur_ref    <= `SCPG_RST_PEAK;
            s_q.tg_st      <= TG_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    // Outputs from state, except drive_enabled, which follows drive_enable_input
    assign prdata                   = s_q.prdata;
    assign pslverr                  = s_q.pslverr;
    assign step_pulse               = s_q.step;
    assign step_dir                 = s_q.dir;
    assign full_step_pulse          = s_q.full_step;
    assign current_ref              = s_q.cur_ref;
    assign peak_current_setting     = s_q.peak;
    assign microstep_res            = s_q.ustep;
    assign electronic_damping_coeff = s_q.damp;
    assign antires_settings         = s_q.area;
    assign antires_active           = |s_q.area;
    assign alarm_out                = s_q.ctrl[`SCPG_CTRL_ALMHI] ? s_q.alarm : ~s_q.alarm;
    assign drive_enabled            = s_q.ctrl[`SCPG_CTRL_ENLOW] ? ~drive_enable_input
                                                                 : drive_enable_input;
    assign drive_reset_pulse        = s_q.drv_rst;
    assign tg_running               = (s_q.tg_st != TG_IDLE);

endmodule : scpg_core

`default_nettype wire

// ---- tb/scpg_core_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module scpg_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        step_pulse,
    input wire logic        full_step_pulse,
    input wire logic        drive_enabled,
    input wire logic        drive_reset_pulse,
    input wire logic        antires_active,
    input wire logic [95:0] antires_settings,
    input wire logic [6:0]  current_ref,
    input wire logic [6:0]  peak_current_setting,
    input wire logic [9:0]  microstep_res
);
    // Single domain, so clock and reset are stated once
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ar_flag_a: assert property (antires_active == |antires_settings)
        else $error("antires flag");
    peak_range_a: assert property (peak_current_setting inside {[7'h01:7'h52]})
        else $error("peak range");
    ustep_range_a: assert property (microstep_res inside {[10'h001:10'h200]})
        else $error("ustep range");
    full_step_a: assert property (full_step_pulse |-> step_pulse)
        else $error("lone full step");
    step_gate_a: assert property (step_pulse |-> $past(drive_enabled))
        else $error("step while off");
    cur_restore_a: assert property (
        step_pulse |-> ##[1:3] current_ref == peak_current_setting) else $error("no restore");
    rst_pulse_a: assert property (drive_reset_pulse |=> !drive_reset_pulse)
        else $error("long reset");
    cur_limit_a: assert property (
        $stable(peak_current_setting)[*3] |-> current_ref <= peak_current_setting)
        else $error("current high");
    cover property (drive_reset_pulse);
    cover property (full_step_pulse);
    cover property (current_ref < peak_current_setting);
endmodule : scpg_chk
bind scpg_core scpg_chk u_chk (.pclk, .presetn, .step_pulse, .full_step_pulse, .drive_enabled,
    .drive_reset_pulse, .antires_active, .antires_settings, .current_ref, .peak_current_setting,
    .microstep_res);
`default_nettype wire

// ---- tb/scpg_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module scpg_ctrl_model (
    input wire logic pclk,
    output logic     cmd_a,
    output logic     cmd_b
);
    initial {cmd_a, cmd_b} = 2'b00;
    // Level on b settles gap periods ahead; gap sets a prompt or slow pace
    task automatic pulses(input int n, input logic b, input logic two, input int gap);
        @(posedge pclk);
        cmd_b <= two ? 1'b0 : b;
        repeat (n)
        begin
            repeat (gap) @(posedge pclk);
            {cmd_b, cmd_a} <= (two && b) ? 2'b10 : {cmd_b, 1'b1};
            repeat (gap) @(posedge pclk);
            {cmd_b, cmd_a} <= two ? 2'b00 : {cmd_b, 1'b0};
        end
    endtask : pulses
endmodule : scpg_ctrl_model
`default_nettype wire

// ---- tb/scpg_core_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, s) checks_done++; \
    if ((s) !== (e)) begin fails++; $display("unexpected %s %0h %0h", n, e, s); end
module scpg_core_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, step_pulse, step_dir;
    logic alarm_out, drive_enabled, tg_running, antires_active, cmd_in_a, cmd_in_b;
    logic drive_enable_input, phase_fault_in, stall_in;
    logic [7:0] paddr;
    logic [6:0] current_ref;
    logic [31:0] pwdata, prdata, rdat;
    int fails, checks_done, nstep, nfwd, n0;
    scpg_core #(.MS_CYCLES(20)) u_dut (.*, .pstrb(4'hF), .edge_selector_switch(1'b0),
        .full_step_pulse(), .peak_current_setting(), .microstep_res(), .drive_reset_pulse(),
        .electronic_damping_coeff(), .antires_settings());
    scpg_ctrl_model u_ctrl (.pclk, .cmd_a(cmd_in_a), .cmd_b(cmd_in_b));
    // Clock and a step tally that the scenarios read
    initial begin pclk = 1'b0; forever #12.5 pclk = ~pclk; end
    always @(posedge pclk) if (step_pulse === 1'b1) {nstep, nfwd} <= {nstep + 1, nfwd + step_dir};
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rdat, perr} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    // Outputs looked at mid-cycle, well clear of the edge
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : tick
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic t_regs();
        apb(0, 8'h0C, 0); `CK("damp", 32'h0BB8, rdat)
        apb(0, 8'h24, 0); `CK("third_area_amplitude", 32'h0080, rdat)
        apb(0, 8'h1C, 0); `CK("second_area_amplitude", 32'h0, rdat)
        `CK("antires", 1'b1, antires_active)
        apb(1, 8'h24, 0);
        apb(1, 8'h28, 0);
        tick(1); `CK("antires", 1'b0, antires_active)
        apb(1, 8'h04, 32'hC8);
        apb(0, 8'h04, 0); `CK("peak", 32'h52, rdat)
        apb(1, 8'h08, 0);
        apb(0, 8'h08, 0); `CK("ustep", 32'h1, rdat)
        apb(0, 8'h80, 0); `CK("slverr", 1'b1, perr)
        $display("registers done");
    endtask : t_regs
    task automatic t_steps();
        n0 = nstep;
        u_ctrl.pulses(3, 1'b1, 1'b0, 2);
        tick(2); `CK("dir", 1'b0, step_dir)
        apb(1, 8'h00, 32'h55);
        u_ctrl.pulses(2, 1'b1, 1'b1, 8);
        tick(8); `CK("ccw", 1'b0, step_dir)
        `CK("steps", 5, nstep - n0)
        apb(1, 8'h00, 32'h14);
        apb(1, 8'h10, 32'h0002_0032);
        tick(80); `CK("idle", 7'h29, current_ref)
        u_ctrl.pulses(1, 1'b0, 1'b0, 2);
        tick(30); `CK("run", 7'h52, current_ref)
        tick(40); `CK("idle", 7'h29, current_ref)
        $display("steps done");
    endtask : t_steps
    task automatic fault(input logic [1:0] v);
        @(posedge pclk);
        {phase_fault_in, stall_in} <= v;
        @(posedge pclk);
        {phase_fault_in, stall_in} <= 2'b00;
        tick(3);
    endtask : fault
    task automatic t_alarm();
        apb(1, 8'h00, 32'h94);
        fault(2'b01); `CK("alarm", 1'b0, alarm_out)
        fault(2'b10); `CK("alarm", 1'b1, alarm_out)
        @(posedge pclk) drive_enable_input <= 1'b0;
        tick(3); `CK("alarm", 1'b0, alarm_out)
        @(posedge pclk) drive_enable_input <= 1'b1;
        apb(1, 8'h00, 32'h28);
        fault(2'b10); `CK("alarm", 1'b1, alarm_out)
        `CK("enable", 1'b0, drive_enabled)
        apb(1, 8'h00, 32'h14);
        $display("alarm done");
    endtask : t_alarm
    task automatic t_tg();
        apb(1, 8'h2C, 32'h0001_0001);
        apb(1, 8'h38, 32'h4);
        n0 = nstep;
        nfwd = 0;
        apb(1, 8'h3C, 32'h1);
        tick(1); `CK("running", 1'b1, tg_running)
        for (int i = 0; i < 9000 && tg_running === 1'b1; i++) @(posedge pclk);
        tick(2); `CK("moves", 400, nstep - n0)
        `CK("forward", 200, nfwd)
        apb(1, 8'h3C, 32'h1);
        apb(1, 8'h3C, 32'h1);
        tick(1); `CK("running", 1'b0, tg_running)
        $display("generator done");
    endtask : t_tg
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {drive_enable_input, phase_fault_in, stall_in} = 3'b100;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_steps();
        t_alarm();
        t_tg();
        tally_and_finish();
    end
    // Several times the cycles the scenarios need
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        tally_and_finish();
    end
endmodule : scpg_core_test
`default_nettype wire
